// >>> core/psbc_pkg.sv
// package: register map, field positions and reset values for the blanking control
package psbc_pkg;
   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] PSBC_OFS_EDGE_BLANK_CTRL = 8'h00;
   localparam logic [7:0] PSBC_OFS_CHAN_AUX_CTRL   = 8'h04;
   localparam logic [7:0] PSBC_OFS_LEB_DURATION    = 8'h08;
   localparam logic [7:0] PSBC_OFS_STATUS          = 8'h0c;

   // ************************************************************
   // edge_blank_control_reg fields
   // ************************************************************
   localparam int PSBC_BIT_HI_RISE_TRIG    = 15;
   localparam int PSBC_BIT_HI_FALL_TRIG    = 14;
   localparam int PSBC_BIT_LO_RISE_TRIG    = 13;
   localparam int PSBC_BIT_LO_FALL_TRIG    = 12;
   localparam int PSBC_BIT_FAULT_LEB_EN    = 11;
   localparam int PSBC_BIT_CL_LEB_EN       = 10;
   localparam int PSBC_BIT_SEL_HIGH_BLANK  = 5;
   localparam int PSBC_BIT_SEL_LOW_BLANK   = 4;
   localparam int PSBC_BIT_HI_HIGH_BLANK   = 3;
   localparam int PSBC_BIT_HI_LOW_BLANK    = 2;
   localparam int PSBC_BIT_LO_HIGH_BLANK   = 1;
   localparam int PSBC_BIT_LO_LOW_BLANK    = 0;
   // bits 9..6 are never stored and read as zero
   localparam logic [15:0] PSBC_EBC_IMPL_MASK = 16'hfc3f;
   localparam logic [15:0] PSBC_EBC_RESET     = 16'h0000;

   // ************************************************************
   // other registers
   // ************************************************************
   localparam int          PSBC_SEL_W          = 2;
   localparam int          PSBC_NUM_BLANK_SRC  = 4;
   localparam int          PSBC_BIT_SEL_LSB    = 0;
   localparam logic [1:0]  PSBC_AUX_SEL_RESET  = 2'h0;
   localparam int          PSBC_LEB_W          = 16;
   localparam logic [15:0] PSBC_LEB_DUR_RESET  = 16'h0000;

   // ************************************************************
   // axi answers
   // ************************************************************
   localparam logic [1:0] PSBC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] PSBC_RESP_SLVERR = 2'h2;
endpackage

// >>> core/psbc_leb_counter.sv
// leading-edge blanking down-counter, restarted by any enabled pwm edge
`timescale 1ns/1ps
`default_nettype none
module psbc_leb_counter #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   // control
   input  wire logic             restart_i,
   input  wire logic [CNT_W-1:0] duration_i,
   // state
   output logic                  active_o
);
   logic [CNT_W-1:0] count_r;

   // a restart during a running window reloads it, so windows never stack
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         count_r <= '0;
      end else if (restart_i) begin
         count_r <= duration_i;
      end else if (count_r != '0) begin
         count_r <= count_r - 1'b1;
      end
   end

   assign active_o = (count_r != '0);
endmodule
`default_nettype wire

// >>> core/psbc_top.sv
// pwm channel state and leading-edge blanking control with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module psbc_top #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input  wire logic                           clk_i,
   input  wire logic                           sys_rst_i,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0]              s_axi_awaddr_i,
   input  wire logic                           s_axi_awvalid_i,
   output logic                                s_axi_awready_o,
   // axi4-lite write data
   input  wire logic [31:0]                    s_axi_wdata_i,
   input  wire logic [3:0]                     s_axi_wstrb_i,
   input  wire logic                           s_axi_wvalid_i,
   output logic                                s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0]                          s_axi_bresp_o,
   output logic                                s_axi_bvalid_o,
   input  wire logic                           s_axi_bready_i,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0]              s_axi_araddr_i,
   input  wire logic                           s_axi_arvalid_i,
   output logic                                s_axi_arready_o,
   output logic [31:0]                         s_axi_rdata_o,
   output logic [1:0]                          s_axi_rresp_o,
   output logic                                s_axi_rvalid_o,
   input  wire logic                           s_axi_rready_i,
   // pwm outputs of this channel, same clock
   input  wire logic                           pwm_high_side_out_i,
   input  wire logic                           pwm_low_side_out_i,
   // external blank sources, current-limit and fault, asynchronous
   input  wire logic [psbc_pkg::PSBC_NUM_BLANK_SRC-1:0] blank_src_i,
   input  wire logic                           cur_limit_i,
   input  wire logic                           fault_i,
   // blanked inputs to the pwm protection logic
   output logic                                cur_limit_blanked_o,
   output logic                                fault_blanked_o
);
   import psbc_pkg::*;

   // ************************************************************
   // registers and synchronisers
   // ************************************************************
   logic [15:0]            ebc_r;
   logic [PSBC_SEL_W-1:0]  aux_sel_r;
   logic [PSBC_LEB_W-1:0]  leb_dur_r;
   logic [PSBC_NUM_BLANK_SRC+1:0] async_s1_r;
   logic [PSBC_NUM_BLANK_SRC+1:0] async_s2_r;
   logic                   pwm_h_d_r;
   logic                   pwm_l_d_r;
   logic                   cl_out_r;
   logic                   flt_out_r;

   // two-flop synchronisers: first stage read only by the second
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         async_s1_r <= '0;
         async_s2_r <= '0;
      end else begin
         async_s1_r <= {fault_i, cur_limit_i, blank_src_i};
         async_s2_r <= async_s1_r;
      end
   end

   wire [PSBC_NUM_BLANK_SRC-1:0] blank_src_sync = async_s2_r[PSBC_NUM_BLANK_SRC-1:0];
   wire cl_sync  = async_s2_r[PSBC_NUM_BLANK_SRC];
   wire flt_sync = async_s2_r[PSBC_NUM_BLANK_SRC+1];

   // ************************************************************
   // state blanking
   // ************************************************************
   // source picked by aux select
   wire sel_blank_sig = blank_src_sync[aux_sel_r];
   wire cond_sel_high = ebc_r[PSBC_BIT_SEL_HIGH_BLANK] & sel_blank_sig;
   wire cond_sel_low  = ebc_r[PSBC_BIT_SEL_LOW_BLANK] & ~sel_blank_sig;
   wire cond_hi_high  = ebc_r[PSBC_BIT_HI_HIGH_BLANK] & pwm_high_side_out_i;
   wire cond_hi_low   = ebc_r[PSBC_BIT_HI_LOW_BLANK] & ~pwm_high_side_out_i;
   wire cond_lo_high  = ebc_r[PSBC_BIT_LO_HIGH_BLANK] & pwm_low_side_out_i;
   wire cond_lo_low   = ebc_r[PSBC_BIT_LO_LOW_BLANK] & ~pwm_low_side_out_i;
   wire state_blank = cond_sel_high | cond_sel_low | cond_hi_high
                    | cond_hi_low | cond_lo_high | cond_lo_low;

   // ************************************************************
   // leading-edge blanking
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pwm_h_d_r <= 1'b0;
         pwm_l_d_r <= 1'b0;
      end else begin
         pwm_h_d_r <= pwm_high_side_out_i;
         pwm_l_d_r <= pwm_low_side_out_i;
      end
   end

   wire leb_restart = (ebc_r[PSBC_BIT_HI_RISE_TRIG] & pwm_high_side_out_i & ~pwm_h_d_r)
                    | (ebc_r[PSBC_BIT_HI_FALL_TRIG] & ~pwm_high_side_out_i & pwm_h_d_r)
                    | (ebc_r[PSBC_BIT_LO_RISE_TRIG] & pwm_low_side_out_i & ~pwm_l_d_r)
                    | (ebc_r[PSBC_BIT_LO_FALL_TRIG] & ~pwm_low_side_out_i & pwm_l_d_r);
   logic leb_active;

   psbc_leb_counter #(
      .CNT_W      (PSBC_LEB_W)
   ) u_leb (
      .clk_i      (clk_i),
      .sys_rst_i  (sys_rst_i),
      .restart_i  (leb_restart),
      .duration_i (leb_dur_r),
      .active_o   (leb_active)
   );

   wire cl_mask  = state_blank | (leb_active & ebc_r[PSBC_BIT_CL_LEB_EN]);
   wire flt_mask = state_blank | (leb_active & ebc_r[PSBC_BIT_FAULT_LEB_EN]);

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cl_out_r  <= 1'b0;
         flt_out_r <= 1'b0;
      end else begin
         cl_out_r  <= cl_sync & ~cl_mask;
         flt_out_r <= flt_sync & ~flt_mask;
      end
   end

   assign cur_limit_blanked_o = cl_out_r;
   assign fault_blanked_o     = flt_out_r;

   // ************************************************************
   // axi4-lite slave
   // ************************************************************
   function automatic logic [3:0] reg_hit(input logic [ADDR_W-1:0] a);
      reg_hit = {a[7:0] == PSBC_OFS_STATUS, a[7:0] == PSBC_OFS_LEB_DURATION,
                 a[7:0] == PSBC_OFS_CHAN_AUX_CTRL, a[7:0] == PSBC_OFS_EDGE_BLANK_CTRL};
   endfunction

   logic              aw_hold_r;
   logic              w_hold_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0]       wdata_r;
   logic [3:0]        wstrb_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              rvalid_r;
   logic [1:0]        rresp_r;
   logic [31:0]       rdata_r;

   assign s_axi_awready_o = ~aw_hold_r & ~bvalid_r;
   assign s_axi_wready_o  = ~w_hold_r & ~bvalid_r;
   assign s_axi_arready_o = ~rvalid_r;

   wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
   wire w_take  = s_axi_wvalid_i & s_axi_wready_o;
   wire do_write = (aw_hold_r | aw_take) & (w_hold_r | w_take) & ~bvalid_r;
   wire [ADDR_W-1:0] wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr_i;
   wire [31:0]       wr_data = w_hold_r ? wdata_r : s_axi_wdata_i;
   wire [3:0]        wr_strb = w_hold_r ? wstrb_r : s_axi_wstrb_i;
   wire [3:0]        wr_hit  = reg_hit(wr_addr);
   wire [15:0]       wr_bmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
   // status is read-only, so a write there is refused
   wire              wr_ok   = |wr_hit[2:0];

   wire ar_take = s_axi_arvalid_i & s_axi_arready_o;
   wire [3:0]  rd_hit = reg_hit(s_axi_araddr_i);
   wire [31:0] status_word = {26'h0, state_blank, leb_active, flt_sync, cl_sync,
                              pwm_low_side_out_i, pwm_high_side_out_i};
   wire [31:0] rd_word = ({32{rd_hit[0]}} & {16'h0, ebc_r})
                       | ({32{rd_hit[1]}} & {{(32-PSBC_SEL_W){1'b0}}, aux_sel_r})
                       | ({32{rd_hit[2]}} & {{(32-PSBC_LEB_W){1'b0}}, leb_dur_r})
                       | ({32{rd_hit[3]}} & status_word);

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
         bvalid_r  <= 1'b0;
         bresp_r   <= PSBC_RESP_OKAY;
      end else begin
         if (do_write) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_ok ? PSBC_RESP_OKAY : PSBC_RESP_SLVERR;
         end else begin
            if (aw_take) begin
               aw_hold_r <= 1'b1;
               awaddr_r  <= s_axi_awaddr_i;
            end
            if (w_take) begin
               w_hold_r <= 1'b1;
               wdata_r  <= s_axi_wdata_i;
               wstrb_r  <= s_axi_wstrb_i;
            end
            if (bvalid_r & s_axi_bready_i) begin
               bvalid_r <= 1'b0;
            end
         end
      end
   end

   // register writes, byte lanes honoured
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ebc_r     <= PSBC_EBC_RESET;
         aux_sel_r <= PSBC_AUX_SEL_RESET;
         leb_dur_r <= PSBC_LEB_DUR_RESET;
      end else if (do_write) begin
         if (wr_hit[0]) begin
            ebc_r <= ((ebc_r & ~wr_bmask) | (wr_data[15:0] & wr_bmask)) & PSBC_EBC_IMPL_MASK;
         end
         if (wr_hit[1] & wr_strb[0]) begin
            aux_sel_r <= wr_data[PSBC_BIT_SEL_LSB +: PSBC_SEL_W];
         end
         if (wr_hit[2]) begin
            leb_dur_r <= (leb_dur_r & ~wr_bmask) | (wr_data[15:0] & wr_bmask);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rvalid_r <= 1'b0;
         rresp_r  <= PSBC_RESP_OKAY;
         rdata_r  <= '0;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rresp_r  <= (|rd_hit) ? PSBC_RESP_OKAY : PSBC_RESP_SLVERR;
         rdata_r  <= rd_word;
      end else if (rvalid_r & s_axi_rready_i) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o  = bresp_r;
   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rresp_o  = rresp_r;
   assign s_axi_rdata_o  = rdata_r;
endmodule
`default_nettype wire

// >>> tb/psbc_top_props.sv
// assertions on the blanking control ports
`timescale 1ns/1ps
`default_nettype none
module psbc_top_props
   import psbc_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic              clk_i,
   input wire logic              sys_rst_i,
   // axi4-lite
   input wire logic              s_axi_awready_o,
   input wire logic              s_axi_wready_o,
   input wire logic [1:0]        s_axi_bresp_o,
   input wire logic              s_axi_bvalid_o,
   input wire logic              s_axi_bready_i,
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic              s_axi_arvalid_i,
   input wire logic              s_axi_arready_o,
   input wire logic [31:0]       s_axi_rdata_o,
   input wire logic [1:0]        s_axi_rresp_o,
   input wire logic              s_axi_rvalid_o,
   input wire logic              s_axi_rready_i,
   // protection inputs and blanked outputs
   input wire logic              cur_limit_i,
   input wire logic              fault_i,
   input wire logic              cur_limit_blanked_o,
   input wire logic              fault_blanked_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   sequence s_rd_take;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   // ************************************************************
   // properties
   // ************************************************************
   // blanking may only remove a level, 2 sync flops plus output flop
   property p_cl_mask;
      cur_limit_blanked_o |-> $past(cur_limit_i, 3);
   endproperty
   a_cl_mask: assert property (p_cl_mask) else $error("cl out without cl in");
   property p_fl_mask;
      fault_blanked_o |-> $past(fault_i, 3);
   endproperty
   a_fl_mask: assert property (p_fl_mask) else $error("fault out without fault in");
   property p_rd_ctrl;
      s_rd_take ##0 (s_axi_araddr_i == 8'h00) |=> s_axi_rvalid_o && (s_axi_rdata_o[9:6] == 4'h0);
   endproperty
   a_rd_ctrl: assert property (p_rd_ctrl) else $error("reserved bits read nonzero");
   property p_rd_bad;
      s_rd_take ##0 (s_axi_araddr_i == 8'h10) |=> s_axi_rresp_o == PSBC_RESP_SLVERR && s_axi_rdata_o == 32'h0;
   endproperty
   a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not refused");
   property p_r_hold;
      s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_b_hold;
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_ar_blk;
      s_axi_rvalid_o |-> !s_axi_arready_o;
   endproperty
   a_ar_blk: assert property (p_ar_blk) else $error("read taken while answer pending");
   property p_aw_blk;
      s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
   endproperty
   a_aw_blk: assert property (p_aw_blk) else $error("write taken while answer pending");
endmodule
bind psbc_top psbc_top_props #(.ADDR_W(ADDR_W)) u_props (
   .clk_i, .sys_rst_i, .s_axi_awready_o, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
   .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
   .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .cur_limit_i, .fault_i,
   .cur_limit_blanked_o, .fault_blanked_o
);
`default_nettype wire

// >>> tb/psbc_top_tb.sv
// self-checking bench: registers, state and edge blanking
`timescale 1ns/1ps
`default_nettype none
module psbc_top_tb;
   import psbc_pkg::*;
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [7:0]  s_axi_awaddr_i = 8'h00;
   logic [7:0]  s_axi_araddr_i = 8'h00;
   logic [31:0] s_axi_wdata_i = 32'h0;
   logic [3:0]  s_axi_wstrb_i = 4'hf;
   logic        s_axi_awvalid_i = 1'b0;
   logic        s_axi_wvalid_i = 1'b0;
   logic        s_axi_bready_i = 1'b0;
   logic        s_axi_arvalid_i = 1'b0;
   logic        s_axi_rready_i = 1'b0;
   logic        pwm_high_side_out_i = 1'b0;
   logic        pwm_low_side_out_i = 1'b0;
   logic [3:0]  blank_src_i = 4'h0;
   logic        cur_limit_i = 1'b0;
   logic        fault_i = 1'b0;
   logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic        cur_limit_blanked_o, fault_blanked_o, lvl;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   logic [31:0] s_axi_rdata_o;
   int          fail_count = 0;
   int          n_compared = 0;
   int          cyc = 0;

   always #2 clk_i = ~clk_i;

   psbc_top u_dut (
      .clk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
      .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
      .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
      .s_axi_rready_i, .pwm_high_side_out_i, .pwm_low_side_out_i, .blank_src_i, .cur_limit_i, .fault_i,
      .cur_limit_blanked_o, .fault_blanked_o
   );
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // answer held back one edge so the slave must keep it standing
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      do begin
         @(posedge clk_i);
         s_axi_awvalid_i <= s_axi_awvalid_i & ~s_axi_awready_o;
         s_axi_wvalid_i <= s_axi_wvalid_i & ~s_axi_wready_o;
      end while ((s_axi_awvalid_i & ~s_axi_awready_o) | (s_axi_wvalid_i & ~s_axi_wready_o));
      @(posedge clk_i);
      s_axi_bready_i <= 1'b1;
      do @(posedge clk_i); while (s_axi_bvalid_o !== 1'b1);
      s_axi_bready_i <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      do @(posedge clk_i); while (s_axi_arready_o !== 1'b1);
      s_axi_arvalid_i <= 1'b0;
      @(posedge clk_i);
      s_axi_rready_i <= 1'b1;
      do @(posedge clk_i); while (s_axi_rvalid_o !== 1'b1);
      s_axi_rready_i <= 1'b0;
      chk("rdata", e, s_axi_rdata_o);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_o});
   endtask
   task automatic blk(input int n, input logic e_cl, input logic e_fl);
      repeat (n) @(posedge clk_i);
      chk("cl_blanked", {31'h0, e_cl}, {31'h0, cur_limit_blanked_o});
      chk("fault_blanked", {31'h0, e_fl}, {31'h0, fault_blanked_o});
   endtask
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // a hang costs a mismatch
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         complete_run();
      end
   end
   // ************************************************************
   // sequence
   // ************************************************************
   initial begin
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd(PSBC_OFS_EDGE_BLANK_CTRL, 32'h0, PSBC_RESP_OKAY);
      rd(PSBC_OFS_CHAN_AUX_CTRL, 32'h0, PSBC_RESP_OKAY);
      wr(PSBC_OFS_EDGE_BLANK_CTRL, 32'hffffffff, PSBC_RESP_OKAY);
      rd(PSBC_OFS_EDGE_BLANK_CTRL, {16'h0, PSBC_EBC_IMPL_MASK}, PSBC_RESP_OKAY);
      wr(8'h10, 32'h1, PSBC_RESP_SLVERR);
      rd(8'h10, 32'h0, PSBC_RESP_SLVERR);
      wr(PSBC_OFS_STATUS, 32'h1, PSBC_RESP_SLVERR);
      cur_limit_i <= 1'b1;
      fault_i <= 1'b1;
      // each enable alone, its condition false then true
      for (int b = 0; b < 6; b++) begin
         wr(PSBC_OFS_EDGE_BLANK_CTRL, 32'h1 << b, PSBC_RESP_OKAY);
         for (int act = 0; act < 2; act++) begin
            lvl = (act == 1) ^ (b % 2 == 0);
            @(posedge clk_i);
            pwm_high_side_out_i <= lvl;
            pwm_low_side_out_i <= lvl;
            blank_src_i <= {4{lvl}};
            blk(5, act == 0, act == 0);
         end
      end
      wr(PSBC_OFS_CHAN_AUX_CTRL, 32'h2, PSBC_RESP_OKAY);
      rd(PSBC_OFS_CHAN_AUX_CTRL, 32'h2, PSBC_RESP_OKAY);
      wr(PSBC_OFS_EDGE_BLANK_CTRL, 32'h20, PSBC_RESP_OKAY);
      blank_src_i <= 4'b1011;
      blk(5, 1'b1, 1'b1);
      blank_src_i <= 4'b0100;
      blk(5, 1'b0, 1'b0);
      // status: state blank, both inputs and both pwm levels high
      rd(PSBC_OFS_STATUS, 32'h2f, PSBC_RESP_OKAY);
      wr(PSBC_OFS_LEB_DURATION, 32'h5, PSBC_RESP_OKAY);
      // low-side rise with current-limit then fault edge blanking
      for (int k = 0; k < 2; k++) begin
         pwm_low_side_out_i <= 1'b0;
         wr(PSBC_OFS_EDGE_BLANK_CTRL, 32'h2000 | (32'h400 << k), PSBC_RESP_OKAY);
         pwm_low_side_out_i <= 1'b1;
         blk(3, k == 1, k == 0);
         blk(4, k == 1, k == 0);
         blk(1, 1'b1, 1'b1);
      end
      // falling trigger only: fall blanks, rise does not
      wr(PSBC_OFS_EDGE_BLANK_CTRL, 32'h1400, PSBC_RESP_OKAY);
      pwm_low_side_out_i <= 1'b0;
      blk(3, 1'b0, 1'b1);
      blk(6, 1'b1, 1'b1);
      pwm_low_side_out_i <= 1'b1;
      blk(3, 1'b1, 1'b1);
      // high-side rise trigger with fault edge blanking
      pwm_high_side_out_i <= 1'b0;
      wr(PSBC_OFS_EDGE_BLANK_CTRL, 32'h8800, PSBC_RESP_OKAY);
      pwm_high_side_out_i <= 1'b1;
      blk(3, 1'b1, 1'b0);
      blk(5, 1'b1, 1'b1);
      // high-side fall trigger gating both inputs
      wr(PSBC_OFS_EDGE_BLANK_CTRL, 32'h4c00, PSBC_RESP_OKAY);
      pwm_high_side_out_i <= 1'b0;
      blk(3, 1'b0, 1'b0);
      blk(5, 1'b1, 1'b1);
      complete_run();
   end
endmodule
`default_nettype wire
